// [inc/bru_defines.vh]
`ifndef BRU_DEFINES_VH
`define BRU_DEFINES_VH

// ==========================================
// instruction fields (bit n of the word is vector bit 31-n)
`define BRU_OP_HI          31
`define BRU_OP_LO          26
`define BRU_SEL_HI         25
`define BRU_SEL_LO         23
`define BRU_REG_HI         25
`define BRU_REG_LO         23
`define BRU_SIZE_HI        22
`define BRU_SIZE_LO        21
`define BRU_IND_BIT        20

// ==========================================
// operation codes, bits 0-5
`define BRU_OPC_COND       6'h3b
`define BRU_OPC_FUNC       6'h3c
`define BRU_OPC_INCR       6'h3d
`define BRU_OPC_LINK       6'h3e

// ==========================================
// status word fields
`define BRU_ADDR_HI        18
`define BRU_ADDR_LO        1
`define BRU_CC_HI          30
`define BRU_CC_LO          27
`define BRU_CC1            30
`define BRU_CC2            29
`define BRU_CC3            28
`define BRU_CC4            27
`define BRU_B5             26
`define BRU_F6_HI          25
`define BRU_F12_LO         19
`define BRU_MASK_TOP       15
`define BRU_PC_STEP        18'h00002
`define BRU_LINK_STEP      32'h00000004
`define BRU_PSW_RESET      32'h00000000
`define BRU_INC_ONE        32'h00000001

// ==========================================
// general registers
`define BRU_LINK_REG       3'h0
`define BRU_MASK_REG       3'h4

// ==========================================
// register port map
`define BRU_ADDR_W         8
`define BRU_REG_PSW        8'h00
`define BRU_REG_STATUS     8'h04
`define BRU_REG_GPR_BASE   8'h20
`define BRU_GPR_SEL_HI     4
`define BRU_GPR_SEL_LO     2
`define BRU_GPR_WIN_HI     7
`define BRU_GPR_WIN_LO     5
`define BRU_GPR_WIN        3'h1
`define BRU_STATUS_PAD     27'h0000000

`endif

// [rtl/bru_gpr_mem.v]
`timescale 1ns/100ps

// ==========================================
// general register file: one write port, two registered read ports
module bru_gpr_mem #(
    parameter DATA_W = 32,
    parameter ADDR_W = 3
) (
    // clock
    input  wire              clk_in,
    // write port
    input  wire              wr_en_in,
    input  wire [ADDR_W-1:0] wr_addr_in,
    input  wire [DATA_W-1:0] wr_data_in,
    // read ports
    input  wire [ADDR_W-1:0] rd_a_addr_in,
    output reg  [DATA_W-1:0] rd_a_data_out,
    input  wire [ADDR_W-1:0] rd_b_addr_in,
    output reg  [DATA_W-1:0] rd_b_data_out
);

    reg [DATA_W-1:0] mem_q [0:(1<<ADDR_W)-1];

    // no reset on the array: contents are software state
    always @(posedge clk_in) begin
        if (wr_en_in) begin
            mem_q[wr_addr_in] <= wr_data_in;
        end
        rd_a_data_out <= mem_q[rd_a_addr_in];
        rd_b_data_out <= mem_q[rd_b_addr_in];
    end

endmodule // bru_gpr_mem

// [rtl/bru_branch_unit.v]
`timescale 1ns/100ps
`include "bru_defines.vh"

module bru_branch_unit #(
    parameter GPR_AW = 3
) (
    // clock and reset
    input  wire                   CLOCK_IN,
    input  wire                   RST_N_IN,
    // instruction request from decode
    input  wire                   INSTR_VALID_IN,
    input  wire [31:0]            INSTR_IN,
    input  wire [31:0]            EFF_ADDR_IN,
    input  wire [31:0]            FINAL_IND_WORD_IN,
    output wire                   READY_OUT,
    // completion
    output reg                    DONE_OUT,
    output reg                    TAKEN_OUT,
    output wire [31:0]            PSW_OUT,
    // register port
    input  wire [`BRU_ADDR_W-1:0] REG_ADDR_IN,
    input  wire [31:0]            REG_WDATA_IN,
    input  wire                   REG_WR_IN,
    input  wire                   REG_RD_IN,
    output reg  [31:0]            REG_RDATA_OUT
);

    // ==========================================
    // state machine
    // one-hot: each state is a single flop
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_READ = 3'b010;
    localparam [2:0] ST_EXEC = 3'b100;

    reg  [2:0]  state_q;
    reg  [2:0]  state_d;
    reg  [31:0] psw_q;
    reg  [31:0] psw_d;
    reg  [31:0] instr_q;
    reg  [31:0] ea_q;
    reg  [31:0] ind_q;
    reg         taken_d;
    reg         done_d;
    reg         last_taken_q;
    reg  [5:0]  last_op_q;
    reg         rd_pend_q;
    reg  [`BRU_ADDR_W-1:0] rd_addr_q;

    wire [5:0]  op_w    = instr_q[`BRU_OP_HI:`BRU_OP_LO];
    wire [2:0]  sel_w   = instr_q[`BRU_SEL_HI:`BRU_SEL_LO];
    wire [1:0]  size_w  = instr_q[`BRU_SIZE_HI:`BRU_SIZE_LO];
    wire        ind_w   = instr_q[`BRU_IND_BIT];
    wire [GPR_AW-1:0] reg_sel_w = instr_q[`BRU_REG_HI:`BRU_REG_LO];
    wire        cc1_w   = psw_q[`BRU_CC1];
    wire        cc2_w   = psw_q[`BRU_CC2];
    wire        cc3_w   = psw_q[`BRU_CC3];
    wire        cc4_w   = psw_q[`BRU_CC4];

    wire        is_idle = state_q[0];
    assign READY_OUT = is_idle;
    assign PSW_OUT   = psw_q;

    // ==========================================
    // general registers
    wire [31:0] gpr_a_w;
    wire [31:0] gpr_b_w;
    reg         gpr_we;
    reg  [GPR_AW-1:0] gpr_waddr;
    reg  [31:0] gpr_wdata;
    // the read address follows the captured word, not the live request lines:
    // decode may move on once its request is taken, so its lines go stale
    wire [GPR_AW-1:0] fsm_raddr = (op_w == `BRU_OPC_FUNC) ?
                                  `BRU_MASK_REG : reg_sel_w;
    wire        bus_gpr_hit = (REG_ADDR_IN[`BRU_GPR_WIN_HI:`BRU_GPR_WIN_LO] == `BRU_GPR_WIN);
    wire [GPR_AW-1:0] bus_gidx = REG_ADDR_IN[`BRU_GPR_SEL_HI:`BRU_GPR_SEL_LO];

    bru_gpr_mem #(
        .DATA_W (32),
        .ADDR_W (GPR_AW)
    ) u_gpr (
        .clk_in        (CLOCK_IN),
        .wr_en_in      (gpr_we),
        .wr_addr_in    (gpr_waddr),
        .wr_data_in    (gpr_wdata),
        .rd_a_addr_in  (fsm_raddr),
        .rd_a_data_out (gpr_a_w),
        .rd_b_addr_in  (bus_gidx),
        .rd_b_data_out (gpr_b_w)
    );

    // ==========================================
    // branch decisions
    reg cond_hit;
    always @* begin
        case (sel_w)
            3'h1:    cond_hit = cc1_w;
            3'h2:    cond_hit = cc2_w;
            3'h3:    cond_hit = cc3_w;
            3'h4:    cond_hit = cc4_w;
            3'h5:    cond_hit = cc2_w | cc4_w;
            3'h6:    cond_hit = cc3_w | cc4_w;
            3'h7:    cond_hit = cc1_w | cc2_w | cc4_w;
            default: cond_hit = 1'b0;
        endcase
    end

    wire [3:0]  fn_idx  = {cc1_w, cc2_w, cc3_w, cc4_w};
    wire [3:0]  fn_pos  = 4'hf - fn_idx;
    wire        fn_hit  = gpr_a_w[fn_pos];
    // trade-off: the mask comes through the register file, costing one state

    wire [31:0] inc_w   = `BRU_INC_ONE << size_w;
    wire [31:0] sum_w   = gpr_a_w + inc_w;
    // carry out of the top bit is dropped: the register wraps to zero
    wire        sum_nz  = |sum_w;

    // sequential step is one word: the address field counts halfwords
    wire [17:0] seq_addr = psw_q[`BRU_ADDR_HI:`BRU_ADDR_LO] + `BRU_PC_STEP;
    wire [17:0] ea_addr  = ea_q[`BRU_ADDR_HI:`BRU_ADDR_LO];

    // ==========================================
    // execute
    always @* begin
        state_d   = state_q;
        psw_d     = psw_q;
        taken_d   = 1'b0;
        done_d    = 1'b0;
        gpr_we    = 1'b0;
        gpr_waddr = bus_gidx;
        gpr_wdata = REG_WDATA_IN;
        case (state_q)
            ST_IDLE: begin
                // a request outranks a register write in the same cycle
                if (INSTR_VALID_IN) begin
                    state_d = ST_READ;
                end else if (REG_WR_IN && bus_gpr_hit) begin
                    // software may only write registers while idle
                    gpr_we = 1'b1;
                end else if (REG_WR_IN && REG_ADDR_IN == `BRU_REG_PSW) begin
                    psw_d = REG_WDATA_IN;
                end
            end
            ST_READ: begin
                // register file is addressed from the captured word here;
                // its data stand in the execute state
                state_d = ST_EXEC;
            end
            ST_EXEC: begin
                state_d = ST_IDLE;
                done_d  = 1'b1;
                psw_d[`BRU_ADDR_HI:`BRU_ADDR_LO] = seq_addr;
                case (op_w)
                    `BRU_OPC_COND: begin
                        if (cond_hit) begin
                            taken_d = 1'b1;
                            psw_d[`BRU_ADDR_HI:`BRU_ADDR_LO] = ea_addr;
                            if (ind_w) begin
                                psw_d[`BRU_CC_HI:`BRU_CC_LO] = ind_q[`BRU_CC_HI:`BRU_CC_LO];
                            end
                        end
                    end
                    `BRU_OPC_FUNC: begin
                        if (fn_hit) begin
                            taken_d = 1'b1;
                            psw_d[`BRU_ADDR_HI:`BRU_ADDR_LO] = ea_addr;
                            if (ind_w) begin
                                psw_d[`BRU_CC_HI:`BRU_CC_LO] = ind_q[`BRU_CC_HI:`BRU_CC_LO];
                                psw_d[`BRU_F6_HI:`BRU_F12_LO] = ind_q[`BRU_F6_HI:`BRU_F12_LO];
                            end
                        end
                    end
                    `BRU_OPC_LINK: begin
                        taken_d   = 1'b1;
                        gpr_we    = 1'b1;
                        gpr_waddr = `BRU_LINK_REG;
                        gpr_wdata = psw_q + `BRU_LINK_STEP;
                        psw_d[`BRU_ADDR_HI:`BRU_ADDR_LO] = ea_addr;
                        if (ind_w) begin
                            psw_d[`BRU_CC_HI:`BRU_CC_LO] = ind_q[`BRU_CC_HI:`BRU_CC_LO];
                        end
                    end
                    `BRU_OPC_INCR: begin
                        gpr_we    = 1'b1;
                        gpr_waddr = reg_sel_w;
                        gpr_wdata = sum_w;
                        if (sum_nz) begin
                            taken_d = 1'b1;
                            psw_d[`BRU_ADDR_HI:`BRU_ADDR_LO] = ea_addr;
                            if (ind_w) begin
                                psw_d[`BRU_CC_HI:`BRU_CC_LO] = ind_q[`BRU_CC_HI:`BRU_CC_LO];
                            end
                        end
                    end
                    default: begin
                        // not a branch: just step on
                        // an unknown operation still completes so decode never stalls
                        taken_d = 1'b0;
                    end
                endcase
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // ==========================================
    // state registers
    always @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state_q      <= ST_IDLE;
            psw_q        <= `BRU_PSW_RESET;
            instr_q      <= 32'h00000000;
            ea_q         <= 32'h00000000;
            ind_q        <= 32'h00000000;
            DONE_OUT     <= 1'b0;
            TAKEN_OUT    <= 1'b0;
            last_taken_q <= 1'b0;
            last_op_q    <= 6'h00;
        end else begin
            state_q  <= state_d;
            psw_q    <= psw_d;
            DONE_OUT <= done_d;
            if (is_idle && INSTR_VALID_IN) begin
                // operands are captured so decode may move on
                instr_q <= INSTR_IN;
                ea_q    <= EFF_ADDR_IN;
                ind_q   <= FINAL_IND_WORD_IN;
            end
            // taken flag and status byte hold until the next completion
            if (done_d) begin
                TAKEN_OUT    <= taken_d;
                last_taken_q <= taken_d;
                last_op_q    <= op_w;
            end
        end
    end

    // ==========================================
    // register read port, data one cycle after the strobe
    always @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rd_pend_q <= 1'b0;
            rd_addr_q <= {`BRU_ADDR_W{1'b0}};
        end else begin
            rd_pend_q <= REG_RD_IN;
            rd_addr_q <= REG_ADDR_IN;
        end
    end

    always @* begin
        REG_RDATA_OUT = 32'h00000000;
        if (rd_pend_q) begin
            if (rd_addr_q[`BRU_GPR_WIN_HI:`BRU_GPR_WIN_LO] == `BRU_GPR_WIN) begin
                REG_RDATA_OUT = gpr_b_w;
            end else if (rd_addr_q == `BRU_REG_PSW) begin
                REG_RDATA_OUT = psw_q;
            end else if (rd_addr_q == `BRU_REG_STATUS) begin
                REG_RDATA_OUT = {`BRU_STATUS_PAD, last_op_q[3:0], last_taken_q} |
                                {31'h00000000, 1'b0} ;
                REG_RDATA_OUT[31] = ~is_idle;
            end
        end
    end

endmodule // bru_branch_unit

// [tb/bru_branch_unit_properties.sv]
`timescale 1ns/100ps
`include "bru_defines.vh"
// ==========================================
// port checks of the branch unit
module bru_branch_checks (
    // clock and reset
    input wire                   CLOCK_IN,
    input wire                   RST_N_IN,
    // instruction side
    input wire                   INSTR_VALID_IN,
    input wire [31:0]            INSTR_IN,
    input wire [31:0]            EFF_ADDR_IN,
    input wire [31:0]            FINAL_IND_WORD_IN,
    input wire                   READY_OUT,
    input wire                   DONE_OUT,
    input wire                   TAKEN_OUT,
    input wire [31:0]            PSW_OUT
);
    wire       take = INSTR_VALID_IN && READY_OUT;
    wire [5:0] op   = INSTR_IN[31:26];
    wire [3:0] cc   = PSW_OUT[30:27];
    logic      hit;
    always_comb begin
        case (INSTR_IN[25:23])
            3'h1: hit = cc[3];
            3'h2: hit = cc[2];
            3'h3: hit = cc[1];
            3'h4: hit = cc[0];
            3'h5: hit = cc[2] | cc[0];
            3'h6: hit = cc[1] | cc[0];
            3'h7: hit = cc[3] | cc[2] | cc[0];
            default: hit = 1'b0;
        endcase
    end
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!RST_N_IN);
    // ==========================================
    // timing
    a_done_time: assert property (take |-> ##1 !DONE_OUT ##1 !DONE_OUT ##1 DONE_OUT)
        else $error("done not three cycles after take");
    a_ready_drop: assert property (take |=> !READY_OUT [*2] ##1 READY_OUT)
        else $error("ready wrong while busy");
    // ==========================================
    // results
    a_cond_pick: assert property (take && op == `BRU_OPC_COND |-> ##3 TAKEN_OUT == $past(hit, 3))
        else $error("condition choice wrong");
    a_cond_target: assert property (take && op == `BRU_OPC_COND && hit |->
        ##3 PSW_OUT[18:1] == $past(EFF_ADDR_IN[18:1], 3)) else $error("branch target wrong");
    a_fall_step: assert property (take && op == `BRU_OPC_COND && !hit |->
        ##3 PSW_OUT[18:1] == $past(PSW_OUT[18:1], 3) + `BRU_PC_STEP) else $error("fall through wrong");
    a_cc_direct: assert property (take && !INSTR_IN[20] |-> ##3 cc == $past(cc, 3))
        else $error("condition code moved on direct");
    a_incr_cc: assert property (take && op == `BRU_OPC_INCR |-> ##3 cc ==
        ((TAKEN_OUT && $past(INSTR_IN[20], 3)) ? $past(FINAL_IND_WORD_IN[30:27], 3) : $past(cc, 3)))
        else $error("increment changed condition code");
    a_link_cc: assert property (take && op == `BRU_OPC_LINK && INSTR_IN[20] |->
        ##3 TAKEN_OUT && cc == $past(FINAL_IND_WORD_IN[30:27], 3)) else $error("link indirect code wrong");
    a_fixed_bits: assert property (take |-> ##3 PSW_OUT[31] == $past(PSW_OUT[31], 3) &&
        PSW_OUT[26] == $past(PSW_OUT[26], 3)) else $error("fixed status bits moved");
    c_func: cover property (take && op == `BRU_OPC_FUNC ##3 TAKEN_OUT);
    c_incr_zero: cover property (take && op == `BRU_OPC_INCR ##3 !TAKEN_OUT);
    c_chained: cover property (take && DONE_OUT);
endmodule // bru_branch_checks

// [tb/bru_decode_model.sv]
`timescale 1ns/100ps
// ==========================================
// decode side: holds each request until taken
module bru_decode_model (
    input  wire        clk_in,
    input  wire        ready_in,
    output reg         valid_out = 1'b0,
    output reg         hang_out  = 1'b0,
    output reg  [31:0] instr_out = 32'h0,
    output reg  [31:0] ea_out    = 32'h0,
    output reg  [31:0] fw_out    = 32'h0
);
    integer n;
    // released lines flip so stale values cannot pass
    task rest;
        valid_out <= 1'b0;
        instr_out <= ~instr_out;
        ea_out    <= ~ea_out;
        fw_out    <= ~fw_out;
    endtask
    task send(input [31:0] ins, input [31:0] ea, input [31:0] fw, input integer lag);
        if (lag > 0) begin
            rest;
            repeat (lag) @(posedge clk_in);
        end
        valid_out <= 1'b1;
        instr_out <= ins;
        ea_out    <= ea;
        fw_out    <= fw;
        n = 0;
        do begin
            @(posedge clk_in);
            n = n + 1;
        end while (ready_in !== 1'b1 && n < 8);
        if (ready_in !== 1'b1) hang_out <= 1'b1;
    endtask
endmodule // bru_decode_model

// [tb/bru_branch_unit_bench.sv]
`timescale 1ns/100ps
`include "bru_defines.vh"
module bru_branch_unit_bench;
    localparam GPR_AW = 3;
    // ==========================================
    // signals and reference state
    reg                   CLOCK_IN, RST_N_IN, REG_WR_IN, REG_RD_IN;
    reg [`BRU_ADDR_W-1:0] REG_ADDR_IN;
    reg [31:0]            REG_WDATA_IN;
    wire                  INSTR_VALID_IN, READY_OUT, DONE_OUT, TAKEN_OUT, hang;
    wire [31:0]           INSTR_IN, EFF_ADDR_IN, FINAL_IND_WORD_IN, PSW_OUT, REG_RDATA_OUT;
    integer               fails = 0, checks = 0, i, n;
    reg [31:0]            rnd = 32'h63, mpsw, d, mgpr [0:7];
    reg [32:0]            e, q [$];
    reg [2:0]             r;
    bru_branch_unit #(.GPR_AW(GPR_AW)) i_bru_branch_unit (.CLOCK_IN(CLOCK_IN), .RST_N_IN(RST_N_IN),
        .INSTR_VALID_IN(INSTR_VALID_IN), .INSTR_IN(INSTR_IN), .EFF_ADDR_IN(EFF_ADDR_IN),
        .FINAL_IND_WORD_IN(FINAL_IND_WORD_IN), .READY_OUT(READY_OUT), .DONE_OUT(DONE_OUT),
        .TAKEN_OUT(TAKEN_OUT), .PSW_OUT(PSW_OUT), .REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN),
        .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN), .REG_RDATA_OUT(REG_RDATA_OUT));
    bru_decode_model i_bru_decode_model (.clk_in(CLOCK_IN), .ready_in(READY_OUT), .valid_out(INSTR_VALID_IN),
        .hang_out(hang), .instr_out(INSTR_IN), .ea_out(EFF_ADDR_IN), .fw_out(FINAL_IND_WORD_IN));
    initial begin
        CLOCK_IN = 1'b0;
        forever #12.5 CLOCK_IN = ~CLOCK_IN;
    end
    // ==========================================
    // helpers
    function [31:0] lfsr(input [31:0] s);
        lfsr = s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
    endfunction
    task nxt;
        rnd = lfsr(rnd);
    endtask
    task automatic chk(input string nm, input [31:0] exp, input [31:0] got);
        checks = checks + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task wrap_up;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task wr(input [7:0] a, input [31:0] v);
        REG_WR_IN <= 1'b1;
        REG_ADDR_IN <= a;
        REG_WDATA_IN <= v;
        @(posedge CLOCK_IN);
        REG_WR_IN <= 1'b0;
        @(posedge CLOCK_IN);
    endtask
    task rd(input [7:0] a);
        REG_RD_IN <= 1'b1;
        REG_ADDR_IN <= a;
        @(posedge CLOCK_IN);
        REG_RD_IN <= 1'b0;
        @(posedge CLOCK_IN);
        d = REG_RDATA_OUT;
    endtask
    // waits until every issued instruction has finished
    task settle;
        i_bru_decode_model.rest;
        n = 0;
        do begin
            @(negedge CLOCK_IN);
            n = n + 1;
        end while ((q.size() != 0 || READY_OUT !== 1'b1) && n < 12);
        if (n >= 12 || hang) begin
            fails = fails + 1;
            wrap_up;
        end
        @(posedge CLOCK_IN);
    endtask
    task setpsw(input [31:0] v);
        settle;
        wr(`BRU_REG_PSW, v);
        mpsw = v;
    endtask
    // reference model of one instruction, queued for the done monitor
    task go(input [31:0] ins, input [31:0] ea, input [31:0] fw, input integer lag);
        reg t;
        t = 1'b0;
        case (ins[31:26])
            `BRU_OPC_COND: t = (ins[25:23] == 1 && mpsw[30]) || (ins[25:23] == 2 && mpsw[29]) ||
                (ins[25:23] == 3 && mpsw[28]) || (ins[25:23] == 4 && mpsw[27]) ||
                (ins[25:23] > 4 && ins[25:23] != 6 && mpsw[29]) || (ins[25:23] > 4 && mpsw[27]) ||
                (ins[25:23] == 6 && mpsw[28]) || (ins[25:23] == 7 && mpsw[30]);
            `BRU_OPC_FUNC: t = mgpr[4][15 - mpsw[30:27]];
            `BRU_OPC_INCR: begin
                mgpr[ins[25:23]] = mgpr[ins[25:23]] + (32'h1 << ins[22:21]);
                t = mgpr[ins[25:23]] != 32'h0;
            end
            `BRU_OPC_LINK: begin
                mgpr[0] = mpsw + 32'h4;
                t = 1'b1;
            end
            default: t = 1'b0;
        endcase
        if (t) mpsw[18:1] = ea[18:1];
        else mpsw[18:1] = mpsw[18:1] + 18'h2;
        if (t && ins[20]) mpsw[30:27] = fw[30:27];
        if (t && ins[20] && ins[31:26] == `BRU_OPC_FUNC) mpsw[25:19] = fw[25:19];
        q.push_back({t, mpsw});
        i_bru_decode_model.send(ins, ea, fw, lag);
    endtask
    always @(posedge CLOCK_IN) begin
        if (RST_N_IN === 1'b1 && DONE_OUT === 1'b1) begin
            e = (q.size() != 0) ? q.pop_front() : 33'h0;
            chk("status word", e[31:0], PSW_OUT);
            chk("taken", {31'h0, e[32]}, {31'h0, TAKEN_OUT});
        end
    end
    // ==========================================
    // scenarios
    initial begin
        RST_N_IN = 1'b0;
        REG_WR_IN = 1'b0;
        REG_RD_IN = 1'b0;
        REG_ADDR_IN = 8'h00;
        REG_WDATA_IN = 32'h0;
        repeat (5) @(posedge CLOCK_IN);
        RST_N_IN <= 1'b1;
        chk("reset status", 32'h0, PSW_OUT);
        for (i = 0; i < 8; i = i + 1) begin
            nxt;
            mgpr[i] = rnd;
            wr({`BRU_GPR_WIN, i[2:0], 2'b00}, rnd);
        end
        rd(8'h08);
        chk("unmapped", 32'h0, d);
        for (i = 0; i < 32; i = i + 1) begin
            nxt;
            if (i % 4 == 0) setpsw(rnd);
            go({`BRU_OPC_COND, i[2:0], 2'b00, rnd[9], rnd[19:0]}, ~rnd, rnd, rnd[3:2] == 2'b00);
        end
        for (i = 0; i < 16; i = i + 1) begin
            nxt;
            setpsw({rnd[31], i[3:0], rnd[26:0]});
            go({`BRU_OPC_FUNC, 3'h4, 2'b00, rnd[7], rnd[19:0]}, ~rnd, rnd, 0);
        end
        settle;
        for (i = 0; i < 16; i = i + 1) begin
            nxt;
            r = rnd[6:4];
            mgpr[r] = i[2] ? -(32'h1 << i[1:0]) : rnd;
            wr({`BRU_GPR_WIN, r, 2'b00}, mgpr[r]);
            go({`BRU_OPC_INCR, r, i[1:0], rnd[8], rnd[19:0]}, ~rnd, rnd, 0);
            settle;
            rd({`BRU_GPR_WIN, r, 2'b00});
            chk("sum", mgpr[r], d);
        end
        for (i = 0; i < 4; i = i + 1) begin
            nxt;
            setpsw(rnd);
            go({`BRU_OPC_LINK, 3'h0, 2'b00, i[0], rnd[19:0]}, ~rnd, rnd, i);
            settle;
            rd(`BRU_REG_GPR_BASE);
            chk("link", mgpr[0], d);
        end
        rd(`BRU_REG_STATUS);
        chk("status", (({26'h0, `BRU_OPC_LINK} << 1) & 32'h1f) | 32'h1, d);
        go({6'h01, 26'h0}, rnd, rnd, 0);
        go({`BRU_OPC_COND, 3'h7, 23'h0}, rnd, ~rnd, 0);
        i_bru_decode_model.rest;
        // let the done monitor pop the finished result before the queue is cleared
        @(posedge CLOCK_IN);
        RST_N_IN <= 1'b0;
        q.delete();
        mpsw = `BRU_PSW_RESET;
        @(negedge CLOCK_IN);
        chk("mid reset", `BRU_PSW_RESET, PSW_OUT);
        chk("mid reset flags", 32'h4, {29'h0, READY_OUT, DONE_OUT, TAKEN_OUT});
        @(posedge CLOCK_IN);
        RST_N_IN <= 1'b1;
        settle;
        rd(`BRU_REG_GPR_BASE);
        chk("kept register", mgpr[0], d);
        wrap_up;
    end
endmodule // bru_branch_unit_bench
bind bru_branch_unit bru_branch_checks i_bru_branch_checks (.CLOCK_IN(CLOCK_IN), .RST_N_IN(RST_N_IN),
    .INSTR_VALID_IN(INSTR_VALID_IN), .INSTR_IN(INSTR_IN), .EFF_ADDR_IN(EFF_ADDR_IN),
    .FINAL_IND_WORD_IN(FINAL_IND_WORD_IN), .READY_OUT(READY_OUT), .DONE_OUT(DONE_OUT),
    .TAKEN_OUT(TAKEN_OUT), .PSW_OUT(PSW_OUT));
